// *** rtl/config_store_pkg.sv ***
package config_store_pkg;

  // ==========================================================================
  // array geometry
  localparam int WORDS = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  localparam int FLAT_W = WORDS * WORD_W;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US_0 = 3;
  localparam int TICK_US_1 = 6;
  localparam int TICK_US_2 = 12;
  localparam int TICK_US_3 = 24;
  localparam int TICK_CYC_0 = TICK_US_0 * 1000 / CLK_PERIOD_NS;
  localparam int TICK_CYC_1 = TICK_US_1 * 1000 / CLK_PERIOD_NS;
  localparam int TICK_CYC_2 = TICK_US_2 * 1000 / CLK_PERIOD_NS;
  localparam int TICK_CYC_3 = TICK_US_3 * 1000 / CLK_PERIOD_NS;
  localparam int TICK_CYC_W = 12;

  // ==========================================================================
  // serial programming frame: four address bits then sixteen data bits
  localparam int FRAME_ADDR_BITS = 4;
  localparam int FRAME_BITS = FRAME_ADDR_BITS + WORD_W;
  localparam logic [4:0] FRAME_LAST = 5'h13;

  // ==========================================================================
  // word indices and field positions
  localparam int W_SERIAL = 0;
  localparam int W_REFRESH = 1;
  localparam int REFRESH_LSB = 0;
  localparam int W_GAIN_MISMATCH_CORR = 2;
  localparam int GAIN_MISMATCH_CORR_LSB = 7;
  localparam int W_COS_DYN = 2;
  localparam int COS_DYN_MSB = 6;
  localparam int W_COS_STAT = 3;
  localparam int COS_STAT_MSB = 12;
  localparam int W_SIN_DYN = 3;
  localparam int SIN_DYN_MSB = 2;
  localparam int W_SIN_STAT = 4;
  localparam int SIN_STAT_MSB = 8;
  localparam int W_LIN_X = 9;
  localparam int LIN_X_MSB = 15;
  localparam int W_LIN_Y = 14;
  localparam int LIN_Y_MSB = 11;
  localparam int W_DIAG = 21;
  localparam int DIAG_LSB = 2;
  localparam int TICK_LSB = 0;
  localparam int W_SENT = 22;
  localparam int SENT_LEN_LSB = 1;
  localparam int SENT_PAUSE_BIT = 0;
  localparam int W_PSI = 23;
  localparam int PSI_ERR_BIT = 4;
  localparam int W_IOSEL = 25;
  localparam int PINC_SEL_LSB = 1;
  localparam int W_LOCK = 26;
  localparam int THR_SRC_LSB = 2;
  localparam int LOCK_LSB = 0;

  // ==========================================================================
  // refresh selector codes
  localparam logic [2:0] REFRESH_MIN = 3'h3;
  localparam logic [2:0] REFRESH_MAX = 3'h6;
  localparam logic [2:0] REFRESH_DEF = 3'h3;

  // serial number halves loaded at reset; values are arbitrary
  localparam logic [15:0] SERIAL_HIGH_DEF = 16'h0000;
  localparam logic [1:0] SERIAL_LOW_DEF = 2'h0;

  // factory image, word 31 first so that index n is word n
  localparam logic [WORDS-1:0][WORD_W-1:0] FACTORY_IMAGE = {
    16'h0000, 16'h0000, 16'h8800, 16'h00FF, 16'h0000, 16'h0000, 16'hE000, 16'h0000,
    16'h0000, 16'h0000, 16'hBFFC, 16'hFFFF, 16'hFF1F, 16'hBFFD, 16'hF9FF,
    16'hFF7F, 16'h3FF5, 16'hF1FF, 16'hFFDF, 16'h9FFB, 16'hF7FF, 16'hFF5F, 16'h1FF3,
    16'h01FF, 16'hFF00, 16'h000F, 16'h7FE0, 16'h0000, 16'h0000, 16'h0000,
    {SERIAL_LOW_DEF, 14'h0003}, SERIAL_HIGH_DEF};

  // ==========================================================================
  // function of the third multi-function pin
  typedef enum logic [2:0] {
    PINC_DAC, PINC_PWM, PINC_PWM_INV, PINC_SENT, PINC_PSI_DRIVE, PINC_CPU_LEVEL, PINC_ADDR_IN
  } pin_c_func_e;

  // decoded configuration handed to the consuming logic
  typedef struct packed {
    logic [2:0] sample_div_code;
    logic signed [6:0] gain_mismatch_corr;
    logic signed [9:0] cos_dynamic_offset;
    logic signed [9:0] cos_static_offset;
    logic signed [9:0] sin_dynamic_offset;
    logic signed [9:0] sin_static_offset;
    logic [6:0][11:0] lin_x;
    logic [6:0][11:0] lin_y;
    logic [10:0] sent_frame_tick_count;
    logic sent_pause_enable;
    logic [TICK_CYC_W-1:0] sent_tick_cycles;
    logic psi_error_check_select;
    logic [1:0] threshold_source_select;
    logic [1:0] array_lock_bits;
    logic [11:0] diag_enable_mask;
    pin_c_func_e pin_c_func;
  } cfg_s;

endpackage

// *** rtl/sensor_config_store.sv ***
`timescale 1ns/1ps
module sensor_config_store (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic prog_enable_pin_in,
  input wire logic multi_function_pin_a_in,
  input wire logic multi_function_pin_b_in,
  input wire logic multi_function_pin_c_in,
  input wire logic supply_programming_mode_in,
  input wire logic [1:0] supply_page_in,
  input wire logic supply_wr_in,
  input wire logic [15:0] supply_data_in,
  input wire logic cpu_wr_in,
  input wire logic [4:0] cpu_addr_in,
  input wire logic [15:0] cpu_wr_data_in,
  input wire logic [11:0] fault_raw_in,
  output logic [15:0] cpu_rd_data_out,
  output logic cpu_wr_refused_out,
  output logic pin_programming_mode_out,
  output logic write_protect_state_out,
  output logic prog_write_done_out,
  output logic pin_c_drive_n_out,
  output logic [11:0] fault_out,
  output config_store_pkg::cfg_s cfg_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [2:0] en_sync;                  // enable pin: two sync stages plus one
    logic [2:0] clk_sync;                 // link clock: two stages plus edge history
    logic [1:0] dat_sync;                 // data pin sync stages
    logic [1:0] adr_sync;                 // third pin sync stages
    logic [config_store_pkg::WORDS-1:0][config_store_pkg::WORD_W-1:0] mem; // the array
    logic [config_store_pkg::FRAME_BITS-1:0] shift; // serial frame assembly
    logic [4:0] bit_cnt;                  // bits taken in the current frame
    logic [15:0] rd_data;                 // read word
    logic wr_refused;                     // refused write pulse, locked or word 0
    logic prog_mode;                      // pin programming mode seen
    logic wp_state;                       // write protection in force
    logic prog_done;                      // serial write committed pulse
    logic pin_c_drive_n;                  // third pin output enable, low drives
    logic [11:0] faults;                  // masked fault results
    config_store_pkg::cfg_s cfg;          // decoded fields
  } state_s;

  state_s q;
  state_s d;

  // ==========================================================================
  // helpers

  // flatten with word 0 at the top, so a field that runs off the end of a
  // word continues into the next word's high bits
  function automatic logic [config_store_pkg::FLAT_W-1:0] flatten(
    input logic [config_store_pkg::WORDS-1:0][config_store_pkg::WORD_W-1:0] m
  );
    logic [config_store_pkg::FLAT_W-1:0] f;
    f = '0;
    for (int i = 0; i < config_store_pkg::WORDS; i++)
    begin
      f[(config_store_pkg::WORDS - 1 - i) * config_store_pkg::WORD_W +: 16] = m[i];
    end
    return f;
  endfunction

  // position in the flat image of bit b of word w
  function automatic int flat_pos(input int w, input int b);
    return (config_store_pkg::WORDS - 1 - w) * config_store_pkg::WORD_W + b;
  endfunction

  // a twelve bit linearisation coordinate, k-th from a start bit
  function automatic logic [11:0] coord(
    input logic [config_store_pkg::FLAT_W-1:0] f,
    input int w,
    input int b,
    input int k
  );
    return f[flat_pos(w, b) - 12 * k -: 12];
  endfunction

  // sent tick period in main clock cycles
  function automatic logic [config_store_pkg::TICK_CYC_W-1:0] tick_cycles(
    input logic [1:0] sel
  );
    logic [config_store_pkg::TICK_CYC_W-1:0] c;
    c = config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_0);
    unique case (sel)
      2'h0: c = config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_0);
      2'h1: c = config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_1);
      2'h2: c = config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_2);
      2'h3: c = config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_3);
    endcase
    return c;
  endfunction

  // ==========================================================================
  // next state
  logic [config_store_pkg::FLAT_W-1:0] flat;
  logic en_now;
  logic clk_rise;
  logic locked;
  logic serial_wr;
  logic [4:0] serial_addr;
  logic [2:0] refresh_raw;
  logic [2:0] pinc_raw;
  logic [15:0] w_diag;
  logic [15:0] w_sent;
  logic [15:0] w_lock;

  // fields are decoded from the array as it stands after this cycle's write,
  // so a new value reaches the outputs on the same edge that stores it
  always_comb
  begin
    d = q;
    // synchronisers: first stage feeds only the second
    d.en_sync = {q.en_sync[1:0], prog_enable_pin_in};
    d.clk_sync = {q.clk_sync[1:0], multi_function_pin_a_in};
    d.dat_sync = {q.dat_sync[0], multi_function_pin_b_in};
    d.adr_sync = {q.adr_sync[0], multi_function_pin_c_in};
    en_now = q.en_sync[1];
    clk_rise = q.clk_sync[1] & ~q.clk_sync[2];
    locked = q.cfg.array_lock_bits != 2'h0;
    d.prog_mode = en_now;
    d.wp_state = locked & ~en_now;
    d.prog_done = 1'b0;
    d.wr_refused = 1'b0;
    serial_wr = 1'b0;
    serial_addr = {q.adr_sync[1], q.shift[config_store_pkg::FRAME_BITS-2 -: 4]};

    // serial frame collection, only while the enable pin stands high
    if (!en_now)
    begin
      // leaving the mode abandons a half-taken frame
      d.bit_cnt = '0;
      d.shift = '0;
    end
    else if (clk_rise)
    begin
      // data bit taken on each rising edge of the link clock
      d.shift = {q.shift[config_store_pkg::FRAME_BITS-2:0], q.dat_sync[1]};
      if (q.bit_cnt == config_store_pkg::FRAME_LAST)
      begin
        // third pin supplies the top address bit of the word
        d.bit_cnt = '0;
        serial_wr = 1'b1;
        serial_addr = {q.adr_sync[1],
          q.shift[config_store_pkg::FRAME_BITS-2 -: config_store_pkg::FRAME_ADDR_BITS]};
      end
      else
      begin
        d.bit_cnt = q.bit_cnt + 5'h1;
      end
    end

    // writes: serial frame first, then supply mode, then the processor
    if (serial_wr)
    begin
      // enable pin is high here, so the lock never refuses it
      d.mem[serial_addr] = {q.shift[14:0], q.dat_sync[1]};
      d.prog_done = 1'b1;
    end
    else if (supply_programming_mode_in && supply_wr_in)
    begin
      // all three pins address a word within the selected page
      if (!locked || en_now)
      begin
        d.mem[{supply_page_in, q.adr_sync[1], q.dat_sync[1], q.clk_sync[1]}] =
          supply_data_in;
      end
      else
      begin
        d.wr_refused = 1'b1;
      end
    end
    else if (cpu_wr_in)
    begin
      // word 0 carries the high half of the factory serial number and is read-only to the processor
      if ((locked && !en_now) || cpu_addr_in == 5'(config_store_pkg::W_SERIAL))
      begin
        d.wr_refused = 1'b1;
      end
      else
      begin
        d.mem[cpu_addr_in] = cpu_wr_data_in;
      end
    end
    d.rd_data = d.mem[cpu_addr_in];

    // field decode from the updated image
    flat = flatten(d.mem);
    refresh_raw = d.mem[config_store_pkg::W_REFRESH][config_store_pkg::REFRESH_LSB +: 3];
    // illegal codes fall back to the factory choice
    if (refresh_raw >= config_store_pkg::REFRESH_MIN &&
        refresh_raw <= config_store_pkg::REFRESH_MAX)
    begin
      d.cfg.sample_div_code = refresh_raw;
    end
    else
    begin
      d.cfg.sample_div_code = config_store_pkg::REFRESH_DEF;
    end
    d.cfg.gain_mismatch_corr =
      d.mem[config_store_pkg::W_GAIN_MISMATCH_CORR][config_store_pkg::GAIN_MISMATCH_CORR_LSB +: 7];
    d.cfg.cos_dynamic_offset = flat[flat_pos(config_store_pkg::W_COS_DYN,
      config_store_pkg::COS_DYN_MSB) -: 10];
    d.cfg.cos_static_offset = flat[flat_pos(config_store_pkg::W_COS_STAT,
      config_store_pkg::COS_STAT_MSB) -: 10];
    d.cfg.sin_dynamic_offset = flat[flat_pos(config_store_pkg::W_SIN_DYN,
      config_store_pkg::SIN_DYN_MSB) -: 10];
    d.cfg.sin_static_offset = flat[flat_pos(config_store_pkg::W_SIN_STAT,
      config_store_pkg::SIN_STAT_MSB) -: 10];
    for (int k = 0; k < 7; k++)
    begin
      d.cfg.lin_x[k] = coord(flat, config_store_pkg::W_LIN_X,
        config_store_pkg::LIN_X_MSB, k);
      d.cfg.lin_y[k] = coord(flat, config_store_pkg::W_LIN_Y,
        config_store_pkg::LIN_Y_MSB, k);
    end

    w_sent = d.mem[config_store_pkg::W_SENT];
    d.cfg.sent_frame_tick_count = w_sent[config_store_pkg::SENT_LEN_LSB +: 11];
    d.cfg.sent_pause_enable = w_sent[config_store_pkg::SENT_PAUSE_BIT];
    w_diag = d.mem[config_store_pkg::W_DIAG];
    d.cfg.sent_tick_cycles = tick_cycles(w_diag[config_store_pkg::TICK_LSB +: 2]);
    d.cfg.diag_enable_mask = w_diag[config_store_pkg::DIAG_LSB +: 12];
    d.cfg.psi_error_check_select =
      d.mem[config_store_pkg::W_PSI][config_store_pkg::PSI_ERR_BIT];
    w_lock = d.mem[config_store_pkg::W_LOCK];
    d.cfg.threshold_source_select = w_lock[config_store_pkg::THR_SRC_LSB +: 2];
    d.cfg.array_lock_bits = w_lock[config_store_pkg::LOCK_LSB +: 2];

    // third pin: an address input in either programming mode, otherwise
    // the output that the stored selector asks for
    pinc_raw = d.mem[config_store_pkg::W_IOSEL][config_store_pkg::PINC_SEL_LSB +: 3];
    if (en_now || supply_programming_mode_in)
    begin
      d.cfg.pin_c_func = config_store_pkg::PINC_ADDR_IN;
      d.pin_c_drive_n = 1'b1;
    end
    else
    begin
      d.pin_c_drive_n = 1'b0;
      unique case (pinc_raw)
        3'h0: d.cfg.pin_c_func = config_store_pkg::PINC_DAC;
        3'h1: d.cfg.pin_c_func = config_store_pkg::PINC_PWM;
        3'h2: d.cfg.pin_c_func = config_store_pkg::PINC_PWM_INV;
        3'h3: d.cfg.pin_c_func = config_store_pkg::PINC_SENT;
        3'h4: d.cfg.pin_c_func = config_store_pkg::PINC_PSI_DRIVE;
        3'h5: d.cfg.pin_c_func = config_store_pkg::PINC_CPU_LEVEL;
        default: d.cfg.pin_c_func = config_store_pkg::PINC_DAC;     // unused codes
      endcase
    end

    // only enabled detectors pass their result on
    d.faults = fault_raw_in & d.cfg.diag_enable_mask;
  end

  // ==========================================================================
  // register stage

  // reset restores the factory image; the real array would keep its
  // contents, which a simulation cannot model without a load step
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.mem <= config_store_pkg::FACTORY_IMAGE;
      q.cfg.sample_div_code <= config_store_pkg::REFRESH_DEF;
      q.cfg.diag_enable_mask <= 12'hFFF;
      q.cfg.sent_tick_cycles <=
        config_store_pkg::TICK_CYC_W'(config_store_pkg::TICK_CYC_0);
      q.cfg.pin_c_func <= config_store_pkg::PINC_DAC;
      q.pin_c_drive_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register; reserved words and bits
  // are never read by the decode above
  assign cfg_out = q.cfg;
  assign cpu_rd_data_out = q.rd_data;
  assign cpu_wr_refused_out = q.wr_refused;
  assign pin_programming_mode_out = q.prog_mode;
  assign write_protect_state_out = q.wp_state;
  assign prog_write_done_out = q.prog_done;
  assign pin_c_drive_n_out = q.pin_c_drive_n;
  assign fault_out = q.faults;

endmodule

// *** bench/sensor_config_store_assertions.sv ***
`timescale 1ns/1ps
// ====
// port checks for the configuration store
module sensor_config_store_checker (
  input logic mclk_in,
  input logic rst_in,
  input logic prog_enable_pin_in,
  input logic multi_function_pin_a_in,
  input logic multi_function_pin_b_in,
  input logic multi_function_pin_c_in,
  input logic supply_programming_mode_in,
  input logic [1:0] supply_page_in,
  input logic supply_wr_in,
  input logic [15:0] supply_data_in,
  input logic cpu_wr_in,
  input logic [4:0] cpu_addr_in,
  input logic [15:0] cpu_wr_data_in,
  input logic [11:0] fault_raw_in,
  input logic [15:0] cpu_rd_data_out,
  input logic cpu_wr_refused_out,
  input logic pin_programming_mode_out,
  input logic write_protect_state_out,
  input logic prog_write_done_out,
  input logic pin_c_drive_n_out,
  input logic [11:0] fault_out,
  input config_store_pkg::cfg_s cfg_out
);
  // one domain, so one clock and one reset for all
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // ====
  // assertions
  a_refresh_legal: assert property (cfg_out.sample_div_code inside {[3'h3:3'h6]})
    else $error("refresh code outside legal range");
  a_part_serial_high_ro: assert property (cpu_wr_in && cpu_addr_in == 5'h00
    && !supply_programming_mode_in && !pin_programming_mode_out |=> cpu_wr_refused_out)
    else $error("write to word zero not refused");
  // enable history guards against the synchroniser lag on the override
  a_lock_refuse: assert property (cpu_wr_in && write_protect_state_out && !prog_enable_pin_in
    && !$past(prog_enable_pin_in) && !$past(prog_enable_pin_in, 2) && !supply_programming_mode_in
    && cfg_out.array_lock_bits != 2'h0 |=> cpu_wr_refused_out) else $error("locked write taken");
  a_mode_unprot: assert property (pin_programming_mode_out && $past(pin_programming_mode_out)
    |-> !write_protect_state_out) else $error("protection shown in programming mode");
  a_pinc_addr: assert property (pin_programming_mode_out ##1 pin_programming_mode_out
    |-> pin_c_drive_n_out && cfg_out.pin_c_func == config_store_pkg::PINC_ADDR_IN)
    else $error("third pin not an address input");
  a_supply_addr: assert property (supply_programming_mode_in ##1 supply_programming_mode_in
    |-> pin_c_drive_n_out) else $error("third pin driven in supply mode");
  a_done_pulse: assert property ($rose(prog_write_done_out) |=> !prog_write_done_out [*8])
    else $error("done pulse too long or repeated");
  a_done_in_mode: assert property (prog_write_done_out |-> $past(pin_programming_mode_out, 2))
    else $error("serial write outside programming mode");
  a_refused_cause: assert property (cpu_wr_refused_out |-> $past(cpu_wr_in) || $past(supply_wr_in))
    else $error("refusal without a request");
  a_fault_mask: assert property ($stable(cfg_out.diag_enable_mask)
    ##1 $stable(cfg_out.diag_enable_mask)
    |-> fault_out == ($past(fault_raw_in) & cfg_out.diag_enable_mask)) else $error("fault mask");
  a_cpu_write: assert property (cpu_wr_in && cpu_addr_in != 5'h00 && !pin_programming_mode_out
    && cfg_out.array_lock_bits == 2'h0 && !supply_programming_mode_in
    |=> cpu_rd_data_out == $past(cpu_wr_data_in)) else $error("written word not read back");
  // main scenarios reached
  c_done: cover property (prog_write_done_out);
  c_refused: cover property (cpu_wr_refused_out);
  c_locked_wr: cover property (write_protect_state_out && cpu_wr_in);
endmodule

bind sensor_config_store sensor_config_store_checker chk_u (
  .mclk_in(mclk_in), .rst_in(rst_in), .prog_enable_pin_in(prog_enable_pin_in),
  .multi_function_pin_a_in(multi_function_pin_a_in), .multi_function_pin_b_in(multi_function_pin_b_in),
  .multi_function_pin_c_in(multi_function_pin_c_in), .supply_page_in(supply_page_in),
  .supply_programming_mode_in(supply_programming_mode_in), .supply_wr_in(supply_wr_in),
  .supply_data_in(supply_data_in), .cpu_wr_in(cpu_wr_in), .cpu_addr_in(cpu_addr_in),
  .cpu_wr_data_in(cpu_wr_data_in), .fault_raw_in(fault_raw_in), .cpu_rd_data_out(cpu_rd_data_out),
  .cpu_wr_refused_out(cpu_wr_refused_out), .pin_programming_mode_out(pin_programming_mode_out),
  .write_protect_state_out(write_protect_state_out), .prog_write_done_out(prog_write_done_out),
  .pin_c_drive_n_out(pin_c_drive_n_out), .fault_out(fault_out), .cfg_out(cfg_out)
);

// *** bench/prog_partner.sv ***
`timescale 1ns/1ps
// ====
// production programmer on the programming pins
module prog_partner (
  output logic prog_enable_pin_out,
  output logic link_clk_out,
  output logic link_data_out,
  output logic addr_pin_out
);
  // all pins start low; the link clock stands still between frames
  initial
  begin
    prog_enable_pin_out = 1'b0;
    link_clk_out = 1'b0;
    link_data_out = 1'b0;
    addr_pin_out = 1'b0;
  end
  // static address on the three pins for supply-pin writes
  task automatic hold_addr(input logic [2:0] adr);
    {addr_pin_out, link_data_out, link_clk_out} = adr;
  endtask
  // address nibble then data, msb first; en low shows a frame the device must ignore
  task automatic send_frame(input logic [4:0] adr, input logic [15:0] dat, input int nbits,
    input logic en);
    logic [19:0] sr;
    sr = {adr[3:0], dat};
    link_clk_out = 1'b0;
    prog_enable_pin_out = en;
    addr_pin_out = adr[4];
    #60;
    for (int i = 0; i < nbits; i++)
    begin
      link_data_out = sr[19-i];
      #62.5 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
    end
    #100 prog_enable_pin_out = 1'b0;
    // released data line must not look like held data
    link_data_out = ~link_data_out;
    // gap long enough for the synchronised enable to fall
    #100;
  endtask
endmodule

// *** bench/sensor_config_store_tb_top.sv ***
`timescale 1ns/1ps
module sensor_config_store_tb_top;
  // ====
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sup_mode = 1'b0;
  logic [1:0] sup_page = 2'h0;
  logic sup_wr = 1'b0;
  logic [15:0] sup_data = 16'h0000;
  logic cpu_wr = 1'b0;
  logic [4:0] cpu_addr = 5'h00;
  logic [15:0] cpu_wd = 16'h0000;
  logic [11:0] fault_raw = 12'h000;
  logic prog_en, pin_a, pin_b, pin_c, refused, pmode, wprot, done, drive_n;
  logic [15:0] rd_data;
  logic [11:0] fault;
  config_store_pkg::cfg_s cfg;
  int error_cnt = 0;
  int checks_done = 0;
  int done_seen = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  // ====
  // design and programmer
  sensor_config_store dut_u (
    .mclk_in(mclk), .rst_in(rst), .prog_enable_pin_in(prog_en), .multi_function_pin_a_in(pin_a),
    .multi_function_pin_b_in(pin_b), .multi_function_pin_c_in(pin_c),
    .supply_programming_mode_in(sup_mode), .supply_page_in(sup_page), .supply_wr_in(sup_wr),
    .supply_data_in(sup_data), .cpu_wr_in(cpu_wr), .cpu_addr_in(cpu_addr),
    .cpu_wr_data_in(cpu_wd), .fault_raw_in(fault_raw), .cpu_rd_data_out(rd_data),
    .cpu_wr_refused_out(refused), .pin_programming_mode_out(pmode),
    .write_protect_state_out(wprot), .prog_write_done_out(done), .pin_c_drive_n_out(drive_n),
    .fault_out(fault), .cfg_out(cfg)
  );
  prog_partner part_u (
    .prog_enable_pin_out(prog_en), .link_clk_out(pin_a), .link_data_out(pin_b),
    .addr_pin_out(pin_c)
  );
  // counted on the falling edge so the pulse is settled
  always @(negedge mclk)
    if (done === 1'b1)
      done_seen++;
  // ====
  // shared tasks
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one processor write; rf is the refusal seen the cycle after
  task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic rf);
    @(posedge mclk) #1 cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wd = d;
    @(posedge mclk) #1 cpu_wr = 1'b0;
    rf = refused;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk) #1 cpu_addr = a;
    @(posedge mclk) #1 d = rd_data;
  endtask
  // ====
  // scenarios
  task automatic t_fields;
    logic rf;
    logic [15:0] v;
    wr(5'h02, 16'hB3A5, rf);
    wr(5'h03, 16'h6C9E, rf);
    wr(5'h04, 16'hD24B, rf);
    wr(5'h05, 16'h8F1F, rf);
    wr(5'h09, 16'hA5B6, rf);
    wr(5'h12, 16'h1234, rf);
    wr(5'h13, 16'hC78D, rf);
    wr(5'h16, 16'h5A5B, rf);
    wr(5'h17, 16'h0010, rf);
    wr(5'h1A, 16'h000C, rf);
    chk(cfg.gain_mismatch_corr[6:0], 32'h67);
    chk(cfg.cos_dynamic_offset[9:0], 32'h12B);
    chk(cfg.cos_static_offset[9:0], 32'h193);
    chk(cfg.sin_dynamic_offset[9:0], 32'h369);
    chk(cfg.lin_x[0], 32'hA5B);
    chk(cfg.lin_y[6], 32'h4C7);
    chk({cfg.sent_frame_tick_count, cfg.sent_pause_enable}, 32'hA5B);
    chk(cfg.psi_error_check_select, 32'h1);
    chk({cfg.threshold_source_select, cfg.array_lock_bits}, 32'hC);
    // flipping every bit of word 5 but bit 15 must leave the split field alone
    wr(5'h05, 16'hF0E0, rf);
    chk(cfg.sin_static_offset[9:0], 32'h097);
    rd(5'h03, v);
    chk(v, 16'h6C9E);
  endtask
  task automatic t_codes;
    logic rf;
    logic [11:0] m;
    for (int k = 0; k < 8; k++)
    begin
      wr(5'h01, {13'h0, k[2:0]}, rf);
      chk(cfg.sample_div_code, (k >= 3 && k <= 6) ? k : 3);
      wr(5'h19, {12'h0, k[2:0], 1'b0}, rf);
      chk(cfg.pin_c_func, (k <= 5) ? k : 0);
      chk(drive_n, 1'b0);
    end
    for (int k = 0; k < 4; k++)
    begin
      m = 12'h249 << k;
      wr(5'h15, {2'b01, m, k[1:0]}, rf);
      fault_raw = 12'hF0F;
      @(posedge mclk) #1;
      chk(cfg.sent_tick_cycles, config_store_pkg::TICK_CYC_0 << k);
      chk(fault, m & 12'hF0F);
    end
  endtask
  task automatic t_lock;
    logic rf;
    logic [15:0] v;
    wr(5'h00, 16'h1234, rf);
    chk(rf, 1'b1);
    wr(5'h02, 16'h0F0F, rf);
    wr(5'h1A, 16'h0001, rf);
    repeat (3) @(posedge mclk) #1;
    chk(wprot, 1'b1);
    wr(5'h02, 16'h1111, rf);
    chk(rf, 1'b1);
    rd(5'h02, v);
    chk(v, 16'h0F0F);
    v = done_seen;
    fork
      part_u.send_frame(5'h1A, 16'h0000, 20, 1'b1);
      begin
        repeat (12) @(posedge mclk) #1;
        chk({pmode, wprot}, 2'b10);
        chk(drive_n, 1'b1);
        chk(cfg.pin_c_func, config_store_pkg::PINC_ADDR_IN);
      end
    join
    chk(done_seen, v + 1);
    chk(cfg.array_lock_bits, 2'h0);
  endtask
  task automatic t_serial;
    logic [15:0] v;
    int n;
    n = done_seen;
    part_u.send_frame(5'h1B, 16'hC3A5, 9, 1'b1);
    part_u.send_frame(5'h1B, 16'hC3A5, 20, 1'b0);
    part_u.send_frame(5'h07, 16'h5AA5, 20, 1'b1);
    chk(done_seen, n + 1);
    rd(5'h1B, v);
    chk(v, 16'h0000);
    rd(5'h07, v);
    chk(v, 16'h5AA5);
  endtask
  task automatic t_supply;
    logic [15:0] v;
    @(posedge mclk) #1 sup_mode = 1'b1;
    sup_page = 2'h1;
    part_u.hold_addr(3'h4);
    repeat (4) @(posedge mclk) #1;
    chk(drive_n, 1'b1);
    sup_data = 16'h9C3E;
    sup_wr = 1'b1;
    @(posedge mclk) #1 sup_wr = 1'b0;
    sup_mode = 1'b0;
    rd(5'h0C, v);
    chk(v, 16'h9C3E);
  endtask
  // ====
  // hang guard and main sequence
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  initial
  begin
    repeat (2) @(posedge mclk) #1;
    rst = 1'b0;
    @(posedge mclk) #1;
    chk({cfg.sample_div_code, pmode, drive_n, wprot}, 6'h18);
    // factory image decode: full mask, evenly spaced linearisation points
    chk(cfg.diag_enable_mask, 32'hFFF);
    chk(cfg.lin_x[6], 32'd3583);
    chk(cfg.lin_y[0], 32'd511);
    chk(cfg.lin_y[6], 32'd3583);
    t_fields;
    t_codes;
    t_lock;
    t_serial;
    t_supply;
    end_sim;
  end
endmodule
